//--- verilog/gain_pkg.sv
// Shared constants and carrier types for the gain and sampling block.
package gain_pkg;

   // --------------------
   // Register byte offsets on the AHB-Lite bus.
   // --------------------
   localparam logic [7:0] OFS_GAIN    = 8'h00; // Analog gain select.
   localparam logic [7:0] OFS_WMODE   = 8'h04; // Waveform mode.
   localparam logic [7:0] OFS_MASK    = 8'h08; // Interrupt mask.
   localparam logic [7:0] OFS_STATUS  = 8'h0C; // Reset-on-read status.
   localparam logic [7:0] OFS_SAMPLE  = 8'h10; // Whole sample word.
   localparam logic [7:0] OFS_BYTE    = 8'h14; // Sample, one byte a read.
   localparam logic [7:0] OFS_INFO    = 8'h18; // Decoded settings.

   // --------------------
   // Field positions and reset values.
   // --------------------
   localparam int CUR_GAIN_LSB  = 0;  // Current amplifier gain, 2 bits.
   localparam int RANGE_LSB     = 3;  // Current full-scale range, 2 bits.
   localparam int VOLT_GAIN_LSB = 5;  // Voltage amplifier gain, 2 bits.
   localparam int INTEG_BIT     = 7;  // Digital integrator enable.
   localparam int PHASE_LSB     = 0;  // Phase select, 2 bits.
   localparam int SOURCE_LSB    = 2;  // Sample source select, 3 bits.
   localparam int RATE_LSB      = 5;  // Sample rate divider, 2 bits.
   localparam int SRDY_BIT      = 0;  // Sample ready flag and enable.
   localparam logic [7:0] GAIN_RESET  = 8'h00;
   localparam logic [7:0] WMODE_RESET = 8'h00;
   localparam logic [2:0] SRC_CURRENT = 3'b000;

   // --------------------
   // Two-bit code meanings and converter limits.
   // --------------------
   localparam logic [1:0] CODE_X1   = 2'b00; // Gain 1 or +-0.5 V.
   localparam logic [1:0] CODE_X2   = 2'b01; // Gain 2 or +-0.25 V.
   localparam logic [1:0] CODE_X4   = 2'b10; // Gain 4 or +-0.125 V.
   localparam logic [23:0] FS_POS   = 24'h28_51EC; // Positive full scale.
   localparam logic [23:0] FS_NEG   = 24'hD7_AE14; // Negative full scale.
   localparam int SAMPLE_BYTES      = 3;  // Bytes per sample word.
   localparam logic [1:0] LAST_BYTE = 2'd2;

   // --------------------
   // Carrier types.
   // --------------------
   // Three converter words, one per phase, index 0 is phase A.
   typedef struct packed
   {
      logic [2:0][23:0] word;
   } phase_words_t;

   // Decoded analog settings, each gain or range field one-hot (x1, x2, x4), plus the integrator bit.
   typedef struct packed
   {
      logic       integ_en;  // Integrator on.
      logic [2:0] volt_gain; // Voltage amplifier gain, one-hot.
      logic [2:0] cur_range; // 0.5 V, 0.25 V, 0.125 V, one-hot.
      logic [2:0] cur_gain;  // Current amplifier gain, one-hot.
   } gain_ctrl_t;

   // Stage of the byte-wise readout.
   typedef enum logic [2:0]
   {
      RD_HIGH = 3'b001,
      RD_MID  = 3'b010,
      RD_LOW  = 3'b100
   } byte_state_t;

endpackage

//--- verilog/sample_rate_div.sv
// Divides the converter word strobe down to the waveform output rate.
`timescale 1ns/1ps
module sample_rate_div
(
   // Clock and reset.
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // Converter strobe and divider setting.
   input  wire logic       tick,
   input  wire logic [1:0] div_sel,
   // One-cycle output strobe.
   output logic            strobe
);

   logic [2:0] cnt_reg;    // Ticks seen since last output strobe.
   logic [2:0] cnt_next;   // Next value of the tick counter.
   logic       strobe_reg; // Registered output strobe.
   logic       strobe_next;
   logic [2:0] last;       // Count that ends a division period.

   // --------------------
   // Next-state logic.
   // --------------------
   // Settings 0..3 divide by 1, 2, 4 and 8 (26.04 down to 3.25 kSPS).
   always_comb
   begin
      last        = 3'((4'd1 << div_sel) - 4'd1);
      cnt_next    = cnt_reg;
      strobe_next = 1'b0;
      if (tick)
      begin
         if (cnt_reg >= last)
         begin
            // A shorter divider set mid-period still ends the period.
            cnt_next    = 3'd0;
            strobe_next = 1'b1;
         end
         else
         begin
            cnt_next = cnt_reg + 3'd1;
         end
      end
   end

   // Registers only.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cnt_reg    <= 3'd0;
         strobe_reg <= 1'b0;
      end
      else
      begin
         cnt_reg    <= cnt_next;
         strobe_reg <= strobe_next;
      end
   end

   assign strobe = strobe_reg;

endmodule

//--- verilog/current_channel_gain_and_sampling.sv
// Gain configuration and current waveform capture with AHB-Lite registers.
//
// Local design decisions: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps

// How it works
// (RL1) Gain bits 1:0 pick current gain
// (RL2) Gain bits 4:3 scale current reference range
// (RL3) Gain bits 6:5 pick voltage gain
// (RL4) Gain bit 7 enables digital integrator
// (RL5) One gain setting serves all phases
// (RL6) Samples are signed 24-bit, 26 kSPS max
// (RL7) Full scale spans 0xD7AE14 to 0x2851EC
// (RL8) Source 000 routes current samples out
// (RL9) Phase select field picks sampled phase
// (RL10) Energy feed never pauses while sampling
// (RL11) Rate divider bits 6:5 set rate
// (RL12) Enabled sample ready pulls interrupt low
// (RL13) Interrupt held until status is read; a one written to status or a cleared mask also releases it
// (RL14) Samples read as three bytes, MSB first
// (RL15) Interrupt pin is active-low open drain
// (RL16) Integrator off after reset
// (RL17) Codes 00/01/10 give x1/x2/x4, 11 reserved
module current_channel_gain_and_sampling
(
   // Clock and reset.
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   // AHB-Lite slave.
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic [31:0]                hrdata,
   output logic                       hreadyout,
   output logic                       hresp,
   // Converter words from the three current inputs.
   input  wire logic                  adc_valid,
   input  wire gain_pkg::phase_words_t adc_words,
   // Energy datapath feed.
   output logic                       energy_valid,
   output gain_pkg::phase_words_t     energy_words,
   // Analog front-end settings.
   output gain_pkg::gain_ctrl_t       gain_ctrl,
   // Interrupt request pin, open drain.
   output logic                       irq_n_o,
   output logic                       irq_n_oe
);

   // --------------------
   // Declarations.
   // --------------------
   logic [7:0]  gain_reg;       // Analog gain select register.
   logic [7:0]  gain_next;
   logic [7:0]  wmode_reg;      // Waveform mode register.
   logic [7:0]  wmode_next;
   logic        mask_reg;       // Sample ready interrupt enable.
   logic        mask_next;
   logic        status_reg;     // Sticky sample ready flag.
   logic        status_next;
   logic [23:0] sample_reg;     // Waveform sample register.
   logic [23:0] sample_next;
   gain_pkg::byte_state_t byte_reg;  // Next byte handed out.
   gain_pkg::byte_state_t byte_next;
   gain_pkg::gain_ctrl_t  ctrl_reg;  // Decoded front-end settings.
   gain_pkg::gain_ctrl_t  ctrl_next;
   logic        reserved_reg;   // A reserved two-bit code is in use.
   logic        reserved_next;
   logic        irq_oe_reg;     // Pin pulled low while set.
   logic        irq_oe_next;
   logic        ev_valid_reg;   // Energy feed strobe.
   gain_pkg::phase_words_t ev_words_reg; // Energy feed words.
   // Bus pipeline state.
   logic        wr_pend_reg;    // Write data phase pending.
   logic        wr_pend_next;
   logic [7:0]  wr_addr_reg;    // Byte offset of that write.
   logic [7:0]  wr_addr_next;
   logic [31:0] rdata_reg;      // Read data for the data phase.
   logic [31:0] rdata_next;
   // Address phase decode.
   logic        access;         // Valid transfer taken this edge.
   logic        rd_acc;         // Read taken this edge.
   logic [7:0]  ofs;            // Byte offset within the block.
   // Sampling datapath.
   logic        rate_strobe;    // Output rate strobe from divider.
   logic        capture;        // New waveform sample this cycle.
   logic [23:0] picked;         // Word of the selected phase.
   logic [23:0] limited;        // Word held inside full scale.
   logic        wr_status;      // Write to the status register.
   logic        rd_status;      // Read of the status register.
   logic        rd_byte;        // Read of the byte readout register.

   // --------------------
   // Output rate divider.
   // --------------------
   // Divides the converter strobe by 1, 2, 4 or 8.
   sample_rate_div u_rate
   (
      .hclk    (hclk),
      .hresetn (hresetn),
      .tick    (adc_valid),
      .div_sel (wmode_reg[gain_pkg::RATE_LSB +: 2]), // [RL11]
      .strobe  (rate_strobe)
   );

   // --------------------
   // Bus decode.
   // --------------------
   // Only NONSEQ and SEQ with hready high start a transfer.
   assign access    = hsel & hready & htrans[1];
   assign rd_acc    = access & ~hwrite;
   assign ofs       = haddr[7:0];
   assign rd_status = rd_acc & (ofs == gain_pkg::OFS_STATUS);
   assign rd_byte   = rd_acc & (ofs == gain_pkg::OFS_BYTE);
   assign wr_status = wr_pend_reg & (wr_addr_reg == gain_pkg::OFS_STATUS);

   // Bus pipeline: writes land in the data phase, reads are fetched at
   // the address edge so the slave never needs a wait state.
   always_comb
   begin
      wr_pend_next = access & hwrite;
      wr_addr_next = access ? ofs : wr_addr_reg;
      rdata_next   = rdata_reg;
      if (rd_acc)
      begin
         case (ofs)
            gain_pkg::OFS_GAIN:   rdata_next = {24'h00_0000, gain_reg};
            gain_pkg::OFS_WMODE:  rdata_next = {24'h00_0000, wmode_reg};
            gain_pkg::OFS_MASK:   rdata_next = {31'h0, mask_reg};
            gain_pkg::OFS_STATUS: rdata_next = {31'h0, status_reg};
            // Sign extended into the top byte.
            gain_pkg::OFS_SAMPLE: rdata_next = {{8{sample_reg[23]}},
                                                sample_reg}; // [RL6]
            gain_pkg::OFS_BYTE:
            begin
               // Most significant byte first. [RL14]
               case (byte_reg)
                  gain_pkg::RD_HIGH:
                     rdata_next = {24'h00_0000, sample_reg[23:16]};
                  gain_pkg::RD_MID:
                     rdata_next = {24'h00_0000, sample_reg[15:8]};
                  gain_pkg::RD_LOW:
                     rdata_next = {24'h00_0000, sample_reg[7:0]};
                  default:
                     rdata_next = 32'h0000_0000;
               endcase
            end
            gain_pkg::OFS_INFO:
               rdata_next = {21'h0, reserved_reg, ctrl_reg};
            // Unmapped offsets read as zero.
            default:              rdata_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         rdata_reg   <= 32'h0000_0000;
      end
      else
      begin
         wr_pend_reg <= wr_pend_next;
         wr_addr_reg <= wr_addr_next;
         rdata_reg   <= rdata_next;
      end
   end

   // --------------------
   // Configuration registers and decoded settings.
   // --------------------
   // Writes take the low byte of hwdata in the data phase.
   always_comb
   begin
      gain_next  = gain_reg;
      wmode_next = wmode_reg;
      mask_next  = mask_reg;
      if (wr_pend_reg)
      begin
         case (wr_addr_reg)
            gain_pkg::OFS_GAIN:  gain_next  = hwdata[7:0];
            gain_pkg::OFS_WMODE: wmode_next = hwdata[7:0];
            gain_pkg::OFS_MASK:  mask_next  = hwdata[gain_pkg::SRDY_BIT];
            default:             gain_next  = gain_reg;
         endcase
      end
   end

   // Decode one two-bit code into one-hot x1/x2/x4; 11 stays at x1 so a
   // reserved value can never request an unbuilt setting.
   function automatic logic [2:0] onehot(input logic [1:0] code);
      case (code)
         gain_pkg::CODE_X1: onehot = 3'b001; // [RL17]
         gain_pkg::CODE_X2: onehot = 3'b010; // [RL17]
         gain_pkg::CODE_X4: onehot = 3'b100; // [RL17]
         default:           onehot = 3'b001;
      endcase
   endfunction

   // The settings are decoded from the next value so that they follow a
   // write on the same edge as the register itself.
   always_comb
   begin
      // One gain field drives every phase of a channel. [RL5]
      ctrl_next.cur_gain  =
         onehot(gain_next[gain_pkg::CUR_GAIN_LSB +: 2]);  // [RL1]
      ctrl_next.cur_range =
         onehot(gain_next[gain_pkg::RANGE_LSB +: 2]);     // [RL2]
      ctrl_next.volt_gain =
         onehot(gain_next[gain_pkg::VOLT_GAIN_LSB +: 2]); // [RL3]
      ctrl_next.integ_en  = gain_next[gain_pkg::INTEG_BIT]; // [RL4]
      reserved_next =
         (&gain_next[gain_pkg::CUR_GAIN_LSB +: 2]) |
         (&gain_next[gain_pkg::RANGE_LSB +: 2]) |
         (&gain_next[gain_pkg::VOLT_GAIN_LSB +: 2]); // [RL17]
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         // Integrator bit clear, so the integrator starts off. [RL16]
         gain_reg     <= gain_pkg::GAIN_RESET;
         wmode_reg    <= gain_pkg::WMODE_RESET;
         mask_reg     <= 1'b0;
         ctrl_reg     <= '{integ_en: 1'b0, volt_gain: 3'b001,
                           cur_range: 3'b001, cur_gain: 3'b001};
         reserved_reg <= 1'b0;
      end
      else
      begin
         gain_reg     <= gain_next;
         wmode_reg    <= wmode_next;
         mask_reg     <= mask_next;
         ctrl_reg     <= ctrl_next;
         reserved_reg <= reserved_next;
      end
   end

   // --------------------
   // Waveform capture.
   // --------------------
   // Phase 11 has no input behind it and falls back to phase C.
   assign picked = (wmode_reg[gain_pkg::PHASE_LSB +: 2] == 2'd3) ?
                   adc_words.word[2] :
                   adc_words.word[wmode_reg[gain_pkg::PHASE_LSB +: 2]];
   // [RL9]

   // Keep the word inside the converter's full-scale swing.
   assign limited =
      ($signed(picked) > $signed(gain_pkg::FS_POS)) ? gain_pkg::FS_POS :
      ($signed(picked) < $signed(gain_pkg::FS_NEG)) ? gain_pkg::FS_NEG :
      picked; // [RL7]

   // Only the current source code produces samples here. [RL8]
   assign capture = rate_strobe &
      (wmode_reg[gain_pkg::SOURCE_LSB +: 3] == gain_pkg::SRC_CURRENT);

   // A new sample restarts the byte readout at the top byte; otherwise
   // each byte read steps on and wraps after the low byte.
   always_comb
   begin
      sample_next = sample_reg;
      byte_next   = byte_reg;
      if (capture)
      begin
         sample_next = limited; // [RL6]
         byte_next   = gain_pkg::RD_HIGH; // [RL14]
      end
      else if (rd_byte)
      begin
         case (byte_reg)
            gain_pkg::RD_HIGH: byte_next = gain_pkg::RD_MID;  // [RL14]
            gain_pkg::RD_MID:  byte_next = gain_pkg::RD_LOW;  // [RL14]
            gain_pkg::RD_LOW:  byte_next = gain_pkg::RD_HIGH; // [RL14]
            default:           byte_next = gain_pkg::RD_HIGH;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sample_reg <= 24'h00_0000;
         byte_reg   <= gain_pkg::RD_HIGH;
      end
      else
      begin
         sample_reg <= sample_next;
         byte_reg   <= byte_next;
      end
   end

   // --------------------
   // Energy feed.
   // --------------------
   // Every converter word goes on to the energy path whatever the
   // waveform settings are, so sampling never stalls accumulation.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ev_valid_reg <= 1'b0;
         ev_words_reg <= '0;
      end
      else
      begin
         ev_valid_reg <= adc_valid; // [RL10]
         ev_words_reg <= adc_valid ? adc_words : ev_words_reg; // [RL10]
      end
   end

   // --------------------
   // Interrupt.
   // --------------------
   // The flag is cleared by reading status or writing a one to it; a
   // sample in the same cycle wins over either clear.
   always_comb
   begin
      status_next = status_reg;
      if (rd_status)
      begin
         status_next = 1'b0; // [RL13]
      end
      if (wr_status & hwdata[gain_pkg::SRDY_BIT])
      begin
         status_next = 1'b0;
      end
      if (capture)
      begin
         status_next = 1'b1; // [RL12]
      end
      // The pin is pulled low while an enabled flag stands. [RL12]
      irq_oe_next = status_next & mask_next; // [RL13]
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         status_reg <= 1'b0;
         irq_oe_reg <= 1'b0;
      end
      else
      begin
         status_reg <= status_next;
         irq_oe_reg <= irq_oe_next;
      end
   end

   // --------------------
   // Outputs.
   // --------------------
   assign hrdata       = rdata_reg;
   assign hreadyout    = 1'b1;
   assign hresp        = 1'b0;
   assign gain_ctrl    = ctrl_reg;
   assign energy_valid = ev_valid_reg;
   assign energy_words = ev_words_reg;
   // Open drain: the pin only ever drives low. [RL15]
   assign irq_n_o      = 1'b0;
   assign irq_n_oe     = irq_oe_reg; // [RL15]

endmodule

//--- tb/gain_sampling_asserts.sv
// Port-level checks for the gain and sampling block.
`timescale 1ns/1ps
module gain_sampling_asserts
(
   // Clock and reset.
   input wire logic                   hclk,
   input wire logic                   hresetn,
   // Bus request side.
   input wire logic                   hsel,
   input wire logic [31:0]            haddr,
   input wire logic [1:0]             htrans,
   input wire logic                   hwrite,
   input wire logic [31:0]            hwdata,
   input wire logic                   hready,
   // Converter feed, energy feed, settings and interrupt.
   input wire logic                   adc_valid,
   input wire gain_pkg::phase_words_t adc_words,
   input wire logic                   energy_valid,
   input wire gain_pkg::phase_words_t energy_words,
   input wire gain_pkg::gain_ctrl_t   gain_ctrl,
   input wire logic                   irq_n_o,
   input wire logic                   irq_n_oe
);
   // --------------------
   // Helper logic.
   // --------------------
   logic gain_dp_reg;  // Gain write is in its data phase.
   logic gain_dp_next; // Gain write taken this cycle.
   logic irq_acc;      // Status or mask access taken this cycle.

   // Only status and mask accesses may release the interrupt.
   assign irq_acc = hsel && hready && htrans[1] &&
                    (haddr[7:0] == gain_pkg::OFS_STATUS ||
                     haddr[7:0] == gain_pkg::OFS_MASK);

   // Next value of the data-phase marker.
   always_comb
      gain_dp_next = hsel && hready && htrans[1] && hwrite &&
                     haddr[7:0] == gain_pkg::OFS_GAIN;

   // Register the marker; the data arrives one cycle after the address.
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         gain_dp_reg <= 1'b0;
      else
         gain_dp_reg <= gain_dp_next;

   // Code to one-hot, reserved code falls back to the x1 setting.
   function automatic logic [2:0] dec(input logic [1:0] c);
      return (c == 2'b01) ? 3'b010 : (c == 2'b10) ? 3'b100 : 3'b001;
   endfunction

   // --------------------
   // Assertions.
   // --------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   chk_energy_copy: assert property
      (adc_valid |=> energy_valid && energy_words == $past(adc_words))
      else $error("energy word lost");
   chk_energy_idle: assert property
      (!adc_valid |=> !energy_valid)
      else $error("stray energy strobe");
   chk_cur_gain: assert property
      (gain_dp_reg |=> gain_ctrl.cur_gain == dec($past(hwdata[1:0])))
      else $error("current gain wrong");
   chk_range_code: assert property
      (gain_dp_reg |=> gain_ctrl.cur_range == dec($past(hwdata[4:3])))
      else $error("current range wrong");
   chk_volt_gain: assert property
      (gain_dp_reg |=> gain_ctrl.volt_gain == dec($past(hwdata[6:5])))
      else $error("voltage gain wrong");
   chk_integ_bit: assert property
      (gain_dp_reg |=> gain_ctrl.integ_en == $past(hwdata[7]))
      else $error("integrator bit wrong");
   chk_gain_hold: assert property
      (!gain_dp_reg |=> $stable(gain_ctrl))
      else $error("settings moved unasked");
   chk_irq_pin: assert property
      (irq_n_o == 1'b0)
      else $error("pin value not low");
   chk_irq_release: assert property
      ($fell(irq_n_oe) |-> $past(irq_acc) || $past(irq_acc, 2))
      else $error("interrupt released unasked");

   cover property (gain_dp_reg);
   cover property ($rose(irq_n_oe));
   cover property ($fell(irq_n_oe));
endmodule

bind current_channel_gain_and_sampling gain_sampling_asserts chk_u
(
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .adc_valid(adc_valid), .adc_words(adc_words),
   .energy_valid(energy_valid), .energy_words(energy_words),
   .gain_ctrl(gain_ctrl), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe)
);

//--- tb/ahb_host.sv
// Host model: single-word AHB-Lite master.
`timescale 1ns/1ps
module ahb_host
(
   // Clock and bus answer.
   input  wire logic   hclk,
   input  wire logic   hready,
   // Request signals.
   output logic        hsel,
   output logic [31:0] haddr,
   output logic [1:0]  htrans,
   output logic        hwrite,
   output logic [2:0]  hsize,
   output logic [31:0] hwdata
);
   // Bus idles with the slave selected and no transfer.
   initial
   begin
      hsel = 1'b1;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0000_0000;
   end

   // One transfer; each phase is held until hready is seen high.
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
      @(posedge hclk);
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
   endtask
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the gain and sampling block.
`timescale 1ns/1ps
module tb_top;
   // --------------------
   // Signals.
   // --------------------
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, adc_valid;
   logic energy_valid, irq_n_o, irq_n_oe, rd_dp;
   logic [31:0] haddr, hwdata, hrdata, seed;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   gain_pkg::phase_words_t adc_words, energy_words;
   gain_pkg::gain_ctrl_t   gain_ctrl;
   logic [31:0] exp_q[$]; // Expected read data, oldest first.
   int mismatches, checks_done, cycles, n;

   current_channel_gain_and_sampling dut_u
   (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .adc_valid(adc_valid), .adc_words(adc_words),
      .energy_valid(energy_valid), .energy_words(energy_words),
      .gain_ctrl(gain_ctrl), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe)
   );
   ahb_host host_u
   (
      .hclk(hclk), .hready(hreadyout), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata)
   );

   // 25 MHz clock.
   initial
   begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end

   // --------------------
   // Helpers.
   // --------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h0400_0007 : 32'h0000_0000);
   endfunction
   function automatic logic [2:0] dec(input logic [1:0] c);
      return (c == 2'b01) ? 3'b010 : (c == 2'b10) ? 3'b100 : 3'b001;
   endfunction
   // Decoded settings as the info word shows them.
   function automatic logic [31:0] info(input logic [7:0] g);
      return {21'h0, (&g[1:0]) | (&g[4:3]) | (&g[6:5]), g[7],
              dec(g[6:5]), dec(g[4:3]), dec(g[1:0])};
   endfunction
   // Out-of-range words are held at full scale, then sign-extended.
   function automatic logic [31:0] clampx(input logic [23:0] w);
      if ($signed(w) > $signed(gain_pkg::FS_POS))
         w = gain_pkg::FS_POS;
      else if ($signed(w) < $signed(gain_pkg::FS_NEG))
         w = gain_pkg::FS_NEG;
      return {{8{w[23]}}, w};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      if (mismatches == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host_u.xfer(1'b1, a, d);
   endtask
   // Note the expected data, then read; the monitor compares.
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      host_u.xfer(1'b0, a, 32'h0000_0000);
   endtask
   // One converter strobe with random words, then time to settle.
   task automatic pulse();
      for (int p = 0; p < 3; p++)
      begin
         seed = lfsr(seed);
         adc_words.word[p] <= seed[23:0];
      end
      @(posedge hclk);
      adc_valid <= 1'b1;
      @(posedge hclk);
      adc_valid <= 1'b0;
      repeat (3) @(posedge hclk);
   endtask

   // Monitor: read data stand in the data phase; also the hang limit.
   always @(posedge hclk)
   begin
      cycles++;
      if (rd_dp && hreadyout === 1'b1)
         check(hrdata, exp_q.pop_front());
      rd_dp <= hsel && hreadyout && htrans[1] && !hwrite;
      if (cycles == 20000)
      begin
         mismatches++;
         conclude();
      end
   end

   // --------------------
   // Main sequence.
   // --------------------
   initial
   begin
      logic [7:0]  g;
      logic [31:0] w;
      hresetn = 1'b0;
      adc_valid = 1'b0;
      adc_words = '0;
      seed = 32'd22;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      rd(gain_pkg::OFS_GAIN, 32'h0000_0000);
      rd(gain_pkg::OFS_INFO, 32'h0000_0049);
      rd(8'h1C, 32'h0000_0000);
      check(hresp, 1'b0);
      // Gain settings, corner codes first, then random ones.
      for (int i = 0; i < 10; i++)
      begin
         seed = lfsr(seed);
         g = (i == 0) ? 8'hFF : (i == 1) ? 8'h80 : seed[7:0];
         wr(gain_pkg::OFS_GAIN, {24'h00_0000, g});
         rd(gain_pkg::OFS_GAIN, {24'h00_0000, g});
         rd(gain_pkg::OFS_INFO, info(g));
      end
      // Every rate and phase; eight strobes give 8 >> rate samples.
      wr(gain_pkg::OFS_MASK, 32'h0000_0001);
      for (int r = 0; r < 4; r++)
      begin
         wr(gain_pkg::OFS_WMODE, (r << 5) | r);
         n = 0;
         for (int k = 0; k < 8; k++)
         begin
            pulse();
            if (irq_n_oe === 1'b1)
            begin
               n++;
               w = clampx(adc_words.word[(r == 3) ? 2 : r]);
               rd(gain_pkg::OFS_STATUS, 32'h0000_0001);
               rd(gain_pkg::OFS_SAMPLE, w);
               rd(gain_pkg::OFS_BYTE, {24'h0, w[23:16]});
               rd(gain_pkg::OFS_BYTE, {24'h0, w[15:8]});
               rd(gain_pkg::OFS_BYTE, {24'h0, w[7:0]});
               repeat (2) @(posedge hclk);
               check(irq_n_oe, 1'b0);
            end
         end
         check(n, 8 >> r);
      end
      // Masked sample: flag set, pin stays quiet.
      wr(gain_pkg::OFS_MASK, 32'h0000_0000);
      wr(gain_pkg::OFS_WMODE, 32'h0000_0000);
      pulse();
      check(irq_n_oe, 1'b0);
      rd(gain_pkg::OFS_STATUS, 32'h0000_0001);
      // Flag set again and cleared by a written one; then another
      // source selected: nothing is captured.
      pulse();
      wr(gain_pkg::OFS_STATUS, 32'h0000_0001);
      wr(gain_pkg::OFS_WMODE, 32'h0000_0004);
      pulse();
      rd(gain_pkg::OFS_STATUS, 32'h0000_0000);
      repeat (2) @(posedge hclk);
      conclude();
   end
endmodule
